// [core/boot_select.sv]
// Purpose: Reset vector choice from fuses and hardware boot pin
// Assumes: Pin is asynchronous to clk_sys
// Notes:   Pin sampled on the first cycles after reset release
`include "flash_ctl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module boot_select
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        boot_vector_fuse,
  input  wire logic        hardware_boot_fuse,
  input  wire logic        hardware_boot_pin_in,
  output logic             hardware_boot_pin_oe_b,
  output logic [15:0]      reset_vector_q,
  output logic             vector_valid_q
);
  logic [2:0] pin_sync_q;
  logic [1:0] settle_q;

  // Pin is always input only, in and out of reset; never driven here
  assign hardware_boot_pin_oe_b = 1'b1; // see [RL3]

  // Three-stage synchroniser for the pin
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      pin_sync_q <= 3'b111;
    else
      pin_sync_q <= {pin_sync_q[1:0], hardware_boot_pin_in};
  end

  // Wait until the synchroniser holds post-release samples
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      settle_q <= 2'b00;
    else if (settle_q != 2'b11)
      settle_q <= settle_q + 2'b01;
  end

  // Vector caught once, after release, as the pin was at the edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reset_vector_q <= 16'h0000;
      vector_valid_q <= 1'b0;
    end
    // Waits for the last stage to hold a post-release sample, else the reset ones agree and a low pin reads as high
    else if (settle_q == 2'b11 && !vector_valid_q && pin_sync_q[1] == pin_sync_q[2])
    begin
      vector_valid_q <= 1'b1;
      if (!boot_vector_fuse) // see [RL1]
        reset_vector_q <= `BOOT_ADDR;
      else if (!hardware_boot_fuse && !pin_sync_q[2]) // see [RL3] see [RL4]
        reset_vector_q <= `BOOT_ADDR;
      else
        reset_vector_q <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [core/flash_ctl.sv]
// Purpose: Store/load program sequencer with APB control registers
// Assumes: CPU gives one-cycle store and load strobes with pointer and data
// Notes:   Fuses are read-only inputs; flash array is outside
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`include "flash_ctl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_ctl
  import flash_ctl_pkg::*;
#(
  parameter int PROG_CYCLES = `PROG_CYCLES
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        global_irq_flag,
  input  wire logic        store_strobe,
  input  wire logic        load_strobe,
  input  wire logic [7:0]  pointer_extension_byte,
  input  wire logic [7:0]  pointer_high_byte,
  input  wire logic [7:0]  pointer_low_byte,
  input  wire logic [7:0]  low_data_register,
  input  wire logic [7:0]  high_data_register,
  input  wire logic [7:0]  fuse_low_byte,
  input  wire logic [7:0]  lock_bits_in,
  input  wire logic [7:0]  signature_byte,
  input  wire logic        boot_vector_fuse,
  input  wire logic        hardware_boot_fuse,
  input  wire logic        hardware_boot_pin_in,
  output logic             hardware_boot_pin_oe_b,
  output logic [15:0]      reset_vector_q,
  output logic [7:0]       load_data_q,
  output logic             load_special_q,
  output logic             store_ready_irq,
  output logic             section_blocked,
  output logic             cpu_halt,
  output flash_req_type    flash_req_q,
  input  wire logic        flash_done,
  output logic             buf_write_q,
  output logic [6:0]       buf_word_q,
  output logic [15:0]      buf_data_q,
  output logic             buf_clear_q,
  output logic [23:0]      load_addr
);
  seq_state_type state_q;
  logic [7:0]  ctrl_q;
  logic [2:0]  win_q;
  logic [31:0] prog_cnt_q;
  logic        halt_q;
  logic        boot_valid;
  logic        ctrl_wr;
  logic        fill_active_q;
  logic [4:0]  wr_cmd;
  logic [15:0] ptr;

  // Decodes the command field of a control byte
  function automatic logic legal_cmd(input logic [4:0] c);
    legal_cmd = (c == `CMD_FILL) || (c == `CMD_ERASE) || (c == `CMD_WRITE)
             || (c == `CMD_LOCK) || (c == `CMD_REEN);
  endfunction

  boot_select u_boot
  (
    .clk_sys                (clk_sys),
    .rst_b                  (rst_b),
    .boot_vector_fuse       (boot_vector_fuse),
    .hardware_boot_fuse     (hardware_boot_fuse),
    .hardware_boot_pin_in   (hardware_boot_pin_in),
    .hardware_boot_pin_oe_b (hardware_boot_pin_oe_b),
    .reset_vector_q         (reset_vector_q),
    .vector_valid_q         (boot_valid)
  );

  // APB: zero wait states, error on unmapped addresses
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == `ADDR_CTRL || paddr == `ADDR_PTR
                 || paddr == `ADDR_DATA || paddr == `ADDR_STRAP);
  assign ctrl_wr = psel && penable && pwrite && paddr == `ADDR_CTRL;
  assign wr_cmd  = pwdata[4:0];
  assign ptr     = {pointer_high_byte, pointer_low_byte};
  // Loads address bytes; extension byte on top of the pointer
  assign load_addr = {pointer_extension_byte, ptr}; // see [RL20] see [RL23]

  // Read mux; fuses only visible, no write path exists to them
  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `ADDR_CTRL:  prdata = {24'h00_0000, ctrl_q};
      `ADDR_PTR:   prdata = {8'h00, load_addr};
      `ADDR_DATA:  prdata = {16'h0000, high_data_register, low_data_register};
      `ADDR_STRAP: prdata = {15'h0000, boot_valid, reset_vector_q}; // see [RL2]
      default:     prdata = 32'h0000_0000;
    endcase
  end

  // Ready interrupt is a level while store enable is clear
  assign store_ready_irq = ctrl_q[`BIT_IRQ_EN] && global_irq_flag
                         && !ctrl_q[`BIT_SEN]; // see [RL5]
  assign section_blocked = ctrl_q[`BIT_BUSY]; // see [RL6]
  assign cpu_halt        = halt_q; // see [RL16]

  // Sequencer and control register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q    <= ST_IDLE;
      ctrl_q     <= `CTRL_RESET;
      win_q      <= 3'd0;
      prog_cnt_q <= 32'd0;
      halt_q     <= 1'b0;
      flash_req_q <= '0;
    end
    else
    begin
      flash_req_q.start <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (ctrl_wr)
          begin
            ctrl_q[`BIT_IRQ_EN] <= pwdata[`BIT_IRQ_EN];
            // Illegal patterns leave command bits untouched
            if (legal_cmd(wr_cmd)) // see [RL19]
            begin
              // Signature select only counts beside store enable alone
              ctrl_q[`BIT_SIG_SEL] <= pwdata[`BIT_SIG_SEL] && wr_cmd == `CMD_FILL; // see [RL10]
              ctrl_q[4:0] <= wr_cmd;
              win_q       <= `STORE_WIN; // see [RL25]
              state_q     <= ST_ARMED;
            end
          end
        end
        ST_ARMED:
        begin
          // Window closes after four cycles; a late load must not wrap the counter
          if (win_q == 3'd1 && !store_strobe)
          begin
            ctrl_q[5:0] <= 6'h00; // see [RL15] see [RL18]
            state_q     <= ST_IDLE;
          end
          else if (store_strobe)
          begin
            ctrl_q[5:0] <= 6'h00;
            state_q     <= ST_IDLE;
            if (ctrl_q[`BIT_SIG_SEL])
            begin
              // Store during signature read does nothing
            end // see [RL10]
            else if (ctrl_q[4:0] == `CMD_REEN)
              ctrl_q[`BIT_BUSY] <= 1'b0; // see [RL7] see [RL8]
            else if (ctrl_q[4:0] == `CMD_FILL)
              ctrl_q[`BIT_BUSY] <= 1'b0; // see [RL7]
            else
            begin
              // Latch address and start a programming operation
              flash_req_q.start <= 1'b1; // see [RL21]
              flash_req_q.addr  <= ptr;
              flash_req_q.data  <= low_data_register; // see [RL11]
              unique case (ctrl_q[4:0])
                `CMD_ERASE: flash_req_q.op <= OP_ERASE; // see [RL14]
                `CMD_WRITE: flash_req_q.op <= OP_WRITE; // see [RL13]
                default:    flash_req_q.op <= OP_LOCK;
              endcase
              ctrl_q[4:0] <= ctrl_q[4:0]; // see [RL18]
              state_q     <= ST_PROG;
              prog_cnt_q  <= 32'(PROG_CYCLES);
              if (ctrl_q[4:0] != `CMD_LOCK)
              begin
                if (ptr >= `HALT_BOUNDARY)
                  halt_q <= 1'b1; // see [RL16]
                else
                  ctrl_q[`BIT_BUSY] <= 1'b1; // see [RL6]
              end
            end
          end
          else if (load_strobe && win_q > 3'd1 && (ctrl_q[`BIT_SIG_SEL] || ctrl_q[`BIT_LOCK]))
          begin
            // Load answered within three cycles; read bits clear after
            ctrl_q[5:0] <= 6'h00; // see [RL10] see [RL12]
            state_q     <= ST_IDLE;
          end
          else
            win_q <= win_q - 3'd1;
        end
        ST_PROG:
        begin
          // Completion by flash done or by the default program time
          if (prog_cnt_q != 32'd0)
            prog_cnt_q <= prog_cnt_q - 32'd1;
          if (flash_done || prog_cnt_q == 32'd1)
          begin
            ctrl_q[4:0] <= 5'b0_0000; // see [RL15] see [RL18]
            halt_q      <= 1'b0;
            state_q     <= ST_IDLE;
          end
          // Control writes are ignored while programming runs
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Special loads: signature, lock bits or fuse low byte by bit zero
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      load_data_q    <= 8'h00;
      load_special_q <= 1'b0;
    end
    else
    begin
      load_special_q <= 1'b0;
      if (state_q == ST_ARMED && load_strobe && win_q > 3'd1)
      begin
        if (ctrl_q[`BIT_SIG_SEL])
        begin
          load_data_q    <= signature_byte; // see [RL10]
          load_special_q <= 1'b1;
        end
        else if (ctrl_q[`BIT_LOCK])
        begin
          load_data_q    <= pointer_low_byte[0] ? lock_bits_in : fuse_low_byte; // see [RL12]
          load_special_q <= 1'b1;
        end
      end
    end
  end

  // Buffer fill and clear strobes toward the page buffer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buf_write_q   <= 1'b0;
      buf_word_q    <= 7'd0;
      buf_data_q    <= 16'h0000;
      buf_clear_q   <= 1'b1; // see [RL24]
      fill_active_q <= 1'b0;
    end
    else
    begin
      buf_write_q <= 1'b0;
      buf_clear_q <= 1'b0;
      if (state_q == ST_ARMED && store_strobe && ctrl_q[4:0] == `CMD_FILL
          && !ctrl_q[`BIT_SIG_SEL])
      begin
        // Word slot ignores the byte select bit
        buf_write_q   <= 1'b1; // see [RL17]
        buf_word_q    <= pointer_low_byte[7:1];
        buf_data_q    <= {high_data_register, low_data_register};
        fill_active_q <= 1'b1;
      end
      if (ctrl_wr && state_q == ST_IDLE && wr_cmd == `CMD_REEN)
      begin
        // Abort load in progress and discard buffer
        buf_clear_q   <= fill_active_q; // see [RL9]
        fill_active_q <= 1'b0;
      end
      if (state_q == ST_ARMED && store_strobe && ctrl_q[4:0] == `CMD_REEN)
        buf_clear_q <= 1'b1; // see [RL24]
      if (state_q == ST_PROG && flash_req_q.op == OP_WRITE
          && (flash_done || prog_cnt_q == 32'd1))
      begin
        buf_clear_q   <= 1'b1; // see [RL24]
        fill_active_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [core/flash_ctl_consts.svh]
// Purpose: Constants for the self-programming flash control block
// Assumes: 50 MHz clk_sys, APB register access, 32-bit data
// Notes:   How it works list follows
// How it works
// [RL1] Boot fuse high selects address zero vector
// [RL2] Fuses are inputs only, never written here
// [RL3] Boot pin used only when boot fuse programmed
// [RL4] Pin low at reset release forces boot vector
// [RL5] Ready interrupt requested while store enable clear
// [RL6] Concurrent section programming sets busy, blocks reads
// [RL7] Busy clears on re-enable or page load
// [RL8] Re-enable store unblocks, ignored while busy
// [RL9] Re-enable write aborts and discards buffer load
// [RL10] Signature read returns byte, store ignored
// [RL11] Lock set store programs lock bits from low
// [RL12] Lock set load returns lock or fuse
// [RL13] Page write stores buffer to pointer page
// [RL14] Page erase clears pointer page
// [RL15] Command bits clear on completion or timeout
// [RL16] Halting section programming stalls processor
// [RL17] Plain store fills buffer word at pointer
// [RL18] Store enable arms four cycles, holds while busy
// [RL19] Only five legal low-bit patterns take effect
// [RL20] Pointer is extension, high and low bytes
// [RL21] Target address latched at operation start
// [RL22] Software uses same page for erase and write
// [RL23] Loads address bytes, bit zero selects byte
// [RL24] Buffer cleared after write, re-enable, reset
// [RL25] Windows count from cycle after control write
`ifndef FLASH_CTL_CONSTS_SVH
`define FLASH_CTL_CONSTS_SVH
`define ADDR_CTRL        12'h000
`define ADDR_PTR         12'h004
`define ADDR_DATA        12'h008
`define ADDR_STRAP       12'h00C
`define CTRL_RESET       8'h00
`define BIT_IRQ_EN       7
`define BIT_BUSY         6
`define BIT_SIG_SEL      5
`define BIT_REEN         4
`define BIT_LOCK         3
`define BIT_PWRT         2
`define BIT_PERS         1
`define BIT_SEN          0
`define CMD_FILL         5'b0_0001
`define CMD_ERASE        5'b0_0011
`define CMD_WRITE        5'b0_0101
`define CMD_LOCK         5'b0_1001
`define CMD_REEN         5'b1_0001
`define STORE_WIN        3'd4
`define LOAD_WIN         3'd3
`define PROG_TIME_US     4000
`define CLK_MHZ          50
`define PROG_CYCLES      (`PROG_TIME_US * `CLK_MHZ)
`define BOOT_ADDR        16'h3800
`define HALT_BOUNDARY    16'h7000
`endif

// [core/flash_ctl_pkg.sv]
// Purpose: Types for the self-programming flash control block
// Assumes: Constants live in flash_ctl_consts.svh
// Notes:   Packed carriers only
package flash_ctl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_PROG = 2'b10
  } seq_state_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ERASE = 3'b001,
    OP_WRITE = 3'b010,
    OP_LOCK = 3'b011
  } flash_op_type;

  typedef struct packed {
    logic        start;
    flash_op_type op;
    logic [15:0] addr;
    logic [7:0]  data;
  } flash_req_type;
endpackage

// [testbench/flash_array_model.sv]
// Purpose: Flash array stand-in answering programming requests
// Assumes: One start pulse per operation
// Notes:   Slow mode stays under the sim programming limit of 20
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_ctl_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire flash_req_type flash_req_q,
  input  wire logic          slow,
  output logic               flash_done
);
  int cnt_q;

  // Counts the programming time, done pulses once at the end
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q      <= 0;
      flash_done <= 1'b0;
    end
    else
    begin
      flash_done <= (cnt_q == 1);
      if (flash_req_q.start)
        cnt_q <= slow ? 15 : 4;
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule
`default_nettype wire

// [testbench/flash_ctl_asserts.sv]
// Purpose: Concurrent checks on the flash control ports
// Assumes: Bound to flash_ctl, one clock, zero-wait APB
// Notes:   Start-to-busy slack of one cycle; busy rises on the same edge as start
`include "flash_ctl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_asserts
  import flash_ctl_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          rst_b,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [11:0]   paddr,
  input wire logic          pslverr,
  input wire logic          global_irq_flag,
  input wire logic          store_ready_irq,
  input wire logic [7:0]    low_data_register,
  input wire logic [7:0]    high_data_register,
  input wire logic          hardware_boot_pin_oe_b,
  input wire logic [15:0]   reset_vector_q,
  input wire flash_req_type flash_req_q,
  input wire logic          buf_write_q,
  input wire logic [15:0]   buf_data_q,
  input wire logic          section_blocked,
  input wire logic          cpu_halt
);
  // Programming starts split by section
  logic prog_start;
  assign prog_start = flash_req_q.start && flash_req_q.op inside {OP_ERASE, OP_WRITE};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Error flag for every offset outside the four registers, unaligned ones too
  a_unmapped_err: assert property (psel && penable
    |-> pslverr == !(paddr inside {`ADDR_CTRL, `ADDR_PTR, `ADDR_DATA, `ADDR_STRAP}))
    else $error("slave error mismatch");
  a_irq_needs_gie: assert property (store_ready_irq |-> global_irq_flag)
    else $error("ready interrupt without global enable");
  a_pin_input: assert property (hardware_boot_pin_oe_b)
    else $error("boot pin driven");
  a_vector_legal: assert property (reset_vector_q inside {16'h0000, `BOOT_ADDR})
    else $error("illegal reset vector");
  a_fill_data: assert property (buf_write_q |-> buf_data_q == $past({high_data_register, low_data_register}))
    else $error("buffer word differs from data pair");
  a_lock_data: assert property (flash_req_q.start && flash_req_q.op == OP_LOCK |-> flash_req_q.data == $past(low_data_register))
    else $error("lock data not from low register");
  a_busy_concurrent: assert property (prog_start && flash_req_q.addr < `HALT_BOUNDARY |-> ##[0:1] section_blocked)
    else $error("busy flag not set");
  a_halt_section: assert property (prog_start && flash_req_q.addr >= `HALT_BOUNDARY |-> ##[0:1] cpu_halt)
    else $error("processor not halted");
  a_start_pulse: assert property (flash_req_q.start |=> !flash_req_q.start)
    else $error("start longer than one cycle");
  a_fill_unblocks: assert property (buf_write_q |-> ##[0:1] !section_blocked)
    else $error("page load left section busy");

  // Main traffic kinds
  c_fill: cover property (buf_write_q);
  c_erase: cover property (prog_start && section_blocked);
  c_halt: cover property (cpu_halt);
endmodule
bind flash_ctl flash_ctl_asserts u_chk (.clk_sys, .rst_b, .psel, .penable, .paddr, .pslverr,
  .global_irq_flag, .store_ready_irq, .low_data_register, .high_data_register,
  .hardware_boot_pin_oe_b, .reset_vector_q, .flash_req_q, .buf_write_q, .buf_data_q,
  .section_blocked, .cpu_halt);
`default_nettype wire

// [testbench/tb.sv]
// Purpose: Self-checking bench for the flash control block
// Assumes: Programming limit shortened to 20 cycles
// Notes:   Random pointer and data, fixed seed
`include "flash_ctl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb
  import flash_ctl_pkg::*;
;
  logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic global_irq_flag = 1'b0, store_strobe = 1'b0, load_strobe = 1'b0, slow = 1'b0;
  logic [7:0] pointer_extension_byte = 8'h00, pointer_high_byte = 8'h00;
  logic [7:0] pointer_low_byte = 8'h00, low_data_register = 8'h00;
  logic [7:0] high_data_register = 8'h00, fuse_low_byte = 8'h00;
  logic [7:0] lock_bits_in = 8'h00, signature_byte = 8'h00, load_data_q;
  logic boot_vector_fuse = 1'b1, hardware_boot_fuse = 1'b1, hardware_boot_pin_in = 1'b1;
  logic pready, pslverr, hardware_boot_pin_oe_b, load_special_q, store_ready_irq;
  logic section_blocked, cpu_halt, flash_done, buf_write_q, buf_clear_q;
  logic [15:0] reset_vector_q, buf_data_q;
  logic [6:0] buf_word_q;
  logic [23:0] load_addr;
  flash_req_type flash_req_q;
  int n_mismatch = 0, checked = 0;
  int n_clear = 0, clr0 = 0;

  flash_ctl #(.PROG_CYCLES(20)) uut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .global_irq_flag, .store_strobe, .load_strobe,
    .pointer_extension_byte, .pointer_high_byte, .pointer_low_byte, .low_data_register,
    .high_data_register, .fuse_low_byte, .lock_bits_in, .signature_byte, .boot_vector_fuse,
    .hardware_boot_fuse, .hardware_boot_pin_in, .hardware_boot_pin_oe_b, .reset_vector_q,
    .load_data_q, .load_special_q, .store_ready_irq, .section_blocked, .cpu_halt,
    .flash_req_q, .flash_done, .buf_write_q, .buf_word_q, .buf_data_q, .buf_clear_q,
    .load_addr);
  flash_array_model u_flash (.clk_sys, .rst_b, .flash_req_q, .slow, .flash_done);

  always #10 clk_sys = ~clk_sys;

  // Counts buffer clear pulses, which are too short for a direct look
  always @(posedge clk_sys)
    if (rst_b && buf_clear_q)
      n_clear <= n_clear + 1;

  // Fuse 0 means programmed; pin only counts with hardware boot fuse programmed
  function automatic logic [15:0] exp_vec(input logic [2:0] f);
    return (!f[2] || (!f[1] && !f[0])) ? `BOOT_ADDR : 16'h0000;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e)
    begin
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      n_mismatch++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer, driven just after an edge; an idle edge after it keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50)
      chk(0, 1, "pready timeout");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic strobe(input bit ld);
    if (ld)
      load_strobe <= 1'b1;
    else
      store_strobe <= 1'b1;
    @(posedge clk_sys);
    load_strobe <= 1'b0;
    store_strobe <= 1'b0;
    #1;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic cmd(input logic [7:0] c, input bit ld);
    apb(1'b1, `ADDR_CTRL, {24'h0000_00, c});
    strobe(ld);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(30576));
    {fuse_low_byte, lock_bits_in, signature_byte} <= 24'($urandom);
    // Every fuse and pin combination through a full reset
    for (int i = 0; i < 8; i++)
    begin
      {boot_vector_fuse, hardware_boot_fuse, hardware_boot_pin_in} <= 3'(i);
      rst_b <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      wt(6);
      apb(1'b0, `ADDR_STRAP, 32'h0000_0000);
      chk(rd[16:0], {1'b1, exp_vec(3'(i))}, "vector");
    end
    apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
    chk(rd[7:0], `CTRL_RESET, "ctrl reset");
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(err, 1'b1, "unmapped");
    // Plain fills with random pointer and data
    repeat (4)
    begin
      {pointer_extension_byte, pointer_high_byte, pointer_low_byte} <= 24'($urandom);
      {high_data_register, low_data_register} <= 16'($urandom);
      cmd(8'h01, 1'b0);
      chk({buf_write_q, buf_word_q, buf_data_q},
          {1'b1, pointer_low_byte[7:1], high_data_register, low_data_register}, "fill");
      chk(load_addr, {pointer_extension_byte, pointer_high_byte, pointer_low_byte}, "ptr");
      apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
      chk(rd[0], 1'b0, "enable after fill");
    end
    // Illegal low-bit patterns leave the register untouched
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, `ADDR_CTRL, (i == 0) ? 32'h0000_0007 : (32'h0000_0002 << i));
      apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
      chk(rd[4:0], 5'h00, "illegal pattern");
    end
    // Armed commands lapse without a store
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, `ADDR_CTRL, {24'h0000_00, k == 0 ? 8'h01 : k == 1 ? 8'h03 : k == 2 ? 8'h05
          : k == 3 ? 8'h09 : 8'h11});
      wt(5);
      apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
      chk(rd[4:0], 5'h00, "window lapse");
    end
    // Slow erase of a concurrent-section page, re-enable refused while busy
    slow <= 1'b1;
    pointer_high_byte <= 8'h12;
    cmd(8'h03, 1'b0);
    chk({flash_req_q.start, flash_req_q.op, flash_req_q.addr},
        {1'b1, OP_ERASE, 8'h12, pointer_low_byte}, "erase");
    pointer_high_byte <= 8'h55;
    wt(2);
    apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
    chk({rd[6], rd[0], section_blocked}, 3'b111, "busy");
    cmd(8'h11, 1'b0);
    wt(1);
    chk(section_blocked, 1'b1, "re-enable while busy");
    wt(20);
    pointer_high_byte <= 8'h12;
    cmd(8'h05, 1'b0);
    chk({flash_req_q.op, flash_req_q.addr[15:8]}, {OP_WRITE, 8'h12}, "write same page");
    wt(20);
    cmd(8'h11, 1'b0);
    chk(buf_clear_q, 1'b1, "buffer cleared");
    wt(2);
    chk(section_blocked, 1'b0, "re-enable");
    // Prompt erase, then a fill clears busy
    slow <= 1'b0;
    cmd(8'h03, 1'b0);
    wt(10);
    cmd(8'h01, 1'b0);
    wt(1);
    chk(section_blocked, 1'b0, "fill clears busy");
    // Re-enable written during a page load throws the loaded words away
    clr0 = n_clear;
    apb(1'b1, `ADDR_CTRL, 32'h0000_0011);
    wt(4);
    chk(n_clear - clr0, 1, "load abort");
    // Halting-section erase
    pointer_high_byte <= 8'h72;
    cmd(8'h03, 1'b0);
    wt(2);
    chk(cpu_halt, 1'b1, "halt");
    wt(12);
    chk(cpu_halt, 1'b0, "halt end");
    // Lock set, lock and fuse read, signature read and ignored store
    low_data_register <= 8'($urandom);
    cmd(8'h09, 1'b0);
    chk({flash_req_q.start, flash_req_q.op, flash_req_q.data}, {1'b1, OP_LOCK, low_data_register}, "lock");
    wt(8);
    for (int z = 0; z < 2; z++)
    begin
      pointer_low_byte <= 8'(z);
      cmd(8'h09, 1'b1);
      chk({load_special_q, load_data_q}, {1'b1, z ? lock_bits_in : fuse_low_byte}, "lock read");
    end
    cmd(8'h21, 1'b1);
    chk(load_data_q, signature_byte, "signature");
    cmd(8'h21, 1'b0);
    chk({flash_req_q.start, buf_write_q}, 2'b00, "signature store");
    // Ready interrupt follows enable, global flag and store enable
    global_irq_flag <= 1'b1;
    apb(1'b1, `ADDR_CTRL, 32'h0000_0080);
    wt(1);
    chk(store_ready_irq, 1'b1, "irq");
    apb(1'b1, `ADDR_CTRL, 32'h0000_0081);
    chk(store_ready_irq, 1'b0, "irq armed");
    global_irq_flag <= 1'b0;
    wt(6);
    chk(store_ready_irq, 1'b0, "irq masked");
    tally_and_finish();
  end
endmodule
`default_nettype wire
